// ==== core/rab_consts.vh ====
// Constants for the register attribute access bank
`ifndef RAB_CONSTS_VH
`define RAB_CONSTS_VH

// Register index in the control window; byte offset is index times four
`define RAB_IDX_RW        0
`define RAB_IDX_LOCK      1
`define RAB_IDX_RO        2
`define RAB_IDX_WO        3
`define RAB_IDX_W1C       4
`define RAB_IDX_STS       5
`define RAB_IDX_SW1C      6
`define RAB_IDX_RESERVED_FIELD      7
`define RAB_IDX_VRW       8
`define RAB_IDX_VLOCK     9
`define RAB_NUM_REGS      10

`define RAB_REG_BITS      32
`define RAB_RST_VAL       32'h00000000

// Portal window layout: one 64-byte portal at the start of each 4 KB page
`define RAB_PAGE_BITS     12
`define RAB_PORTAL_BITS   512
`define RAB_PORTAL_FILL   8'hFF

`endif

// ==== core/rab_bank.v ====
// Register bank with per-class field attributes, a 64-bit access port and a portal window
// Behaviour
// - eight-byte access services two adjacent registers
// - read-write field returns last written value
// - lockable field writable only while unlocked
// - read-only field hardware driven, writes ignored
// - write-only field accepts writes, reads zero
// - writing one clears bit, zero ignored
// - sticky status read-only, survives device reset
// - sticky clear-on-one bit survives device reset
// - reserved field reads zero, writes discarded
// - volatile field written by software and hardware
// - volatile lockable: locked writes ignored, hardware updates
// - unmatched portal writes ignored, reads return fill
`timescale 1ns/1ps
`include "rab_consts.vh"

module rab_bank #(
  parameter AW          = 12,
  parameter PAW         = 16,
  parameter NUM_PORTALS = 16
) (
  input  wire                        i_clk,
  input  wire                        i_resetn,
  input  wire                        i_sticky_resetn,
  input  wire                        i_req,
  input  wire                        i_write,
  input  wire [AW-1:0]               i_addr,
  input  wire [7:0]                  i_be,
  input  wire [63:0]                 i_wdata,
  output reg  [63:0]                 o_rdata,
  output reg                         o_rvalid,
  input  wire                        i_lock,
  input  wire [31:0]                 i_ro_status,
  input  wire [31:0]                 i_sts_status,
  input  wire [31:0]                 i_w1c_set,
  input  wire [31:0]                 i_sw1c_set,
  input  wire                        i_vrw_we,
  input  wire [31:0]                 i_vrw_data,
  input  wire                        i_vlock_we,
  input  wire [31:0]                 i_vlock_data,
  output reg  [31:0]                 o_rw,
  output reg  [31:0]                 o_lock,
  output reg  [31:0]                 o_wo,
  output reg                         o_wo_strobe,
  output reg  [31:0]                 o_w1c,
  output reg  [31:0]                 o_sw1c,
  output reg  [31:0]                 o_vrw,
  output reg  [31:0]                 o_vlock,
  input  wire                        i_portal_req,
  input  wire                        i_portal_write,
  input  wire [PAW-1:0]              i_portal_addr,
  input  wire [`RAB_PORTAL_BITS-1:0] i_portal_wdata,
  output reg                         o_portal_valid,
  output reg  [PAW-`RAB_PAGE_BITS-1:0] o_portal_index,
  output reg  [`RAB_PORTAL_BITS-1:0] o_portal_data,
  output reg  [63:0]                 o_portal_rdata,
  output reg                         o_portal_rvalid
);

  localparam NR = `RAB_NUM_REGS;
  localparam RB = `RAB_REG_BITS;
  localparam QW = AW - 3;
  localparam PW = PAW - `RAB_PAGE_BITS;

  wire [NR*RB-1:0] wmask;
  wire [NR*RB-1:0] wdat;
  wire [NR*RB-1:0] rdall;
  reg  [31:0]      sts;
  wire [QW-1:0]    qaddr;
  wire             wr;

  assign qaddr = i_addr[AW-1:3];
  assign wr    = i_req & i_write;

  // Each register owns one half of the 64-bit lanes; both halves share one access
  genvar j;
  generate
    for (j = 0; j < NR; j = j + 1) begin : g_lane
      localparam integer QI = j / 2;
      wire       hit;
      wire [3:0] be4;
      // Writes past the last register match no lane and are dropped
      assign hit = wr & (qaddr == QI[QW-1:0]);
      assign be4 = hit ? i_be[(j%2)*4 +: 4] : 4'h0;
      assign wmask[j*RB +: RB] = {{8{be4[3]}}, {8{be4[2]}}, {8{be4[1]}}, {8{be4[0]}}};
      assign wdat[j*RB +: RB]  = i_wdata[(j%2)*32 +: 32];
    end
  endgenerate

  wire [31:0] m_rw    = wmask[`RAB_IDX_RW*RB +: RB];
  wire [31:0] m_lock  = wmask[`RAB_IDX_LOCK*RB +: RB];
  wire [31:0] m_wo    = wmask[`RAB_IDX_WO*RB +: RB];
  wire [31:0] m_w1c   = wmask[`RAB_IDX_W1C*RB +: RB];
  wire [31:0] m_sw1c  = wmask[`RAB_IDX_SW1C*RB +: RB];
  wire [31:0] m_vrw   = wmask[`RAB_IDX_VRW*RB +: RB];
  wire [31:0] m_vlock = wmask[`RAB_IDX_VLOCK*RB +: RB];
  wire [31:0] d_rw    = wdat[`RAB_IDX_RW*RB +: RB];
  wire [31:0] d_lock  = wdat[`RAB_IDX_LOCK*RB +: RB];
  wire [31:0] d_wo    = wdat[`RAB_IDX_WO*RB +: RB];
  wire [31:0] d_w1c   = wdat[`RAB_IDX_W1C*RB +: RB];
  wire [31:0] d_sw1c  = wdat[`RAB_IDX_SW1C*RB +: RB];
  wire [31:0] d_vrw   = wdat[`RAB_IDX_VRW*RB +: RB];
  wire [31:0] d_vlock = wdat[`RAB_IDX_VLOCK*RB +: RB];

  // Fields cleared by the device reset
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rw        <= `RAB_RST_VAL;
      o_lock      <= `RAB_RST_VAL;
      o_wo        <= `RAB_RST_VAL;
      o_wo_strobe <= 1'b0;
      o_w1c       <= `RAB_RST_VAL;
      o_vrw       <= `RAB_RST_VAL;
      o_vlock     <= `RAB_RST_VAL;
    end else begin
      o_rw <= (o_rw & ~m_rw) | (d_rw & m_rw);
      if (!i_lock) begin
        o_lock <= (o_lock & ~m_lock) | (d_lock & m_lock);
      end
      o_wo        <= (o_wo & ~m_wo) | (d_wo & m_wo);
      // Strobe lets the consumer pick up a value that can never be read back
      o_wo_strobe <= |m_wo;
      // A hardware set in the same cycle as a clear keeps the bit set
      o_w1c <= (o_w1c & ~(d_w1c & m_w1c)) | i_w1c_set;
      // Hardware update takes priority over a same-cycle software write
      if (i_vrw_we) begin
        o_vrw <= i_vrw_data;
      end else begin
        o_vrw <= (o_vrw & ~m_vrw) | (d_vrw & m_vrw);
      end
      // Lock holds off software only; hardware keeps loading status
      if (i_vlock_we) begin
        o_vlock <= i_vlock_data;
      end else if (!i_lock) begin
        o_vlock <= (o_vlock & ~m_vlock) | (d_vlock & m_vlock);
      end
    end
  end

  // Sticky fields only answer to the sticky reset, so a device reset leaves them intact
  always @(posedge i_clk or negedge i_sticky_resetn) begin
    if (!i_sticky_resetn) begin
      sts    <= `RAB_RST_VAL;
      o_sw1c <= `RAB_RST_VAL;
    end else begin
      sts    <= i_sts_status;
      o_sw1c <= (o_sw1c & ~(d_sw1c & m_sw1c)) | i_sw1c_set;
    end
  end

  assign rdall[`RAB_IDX_RW*RB +: RB]    = o_rw;
  assign rdall[`RAB_IDX_LOCK*RB +: RB]  = o_lock;
  assign rdall[`RAB_IDX_RO*RB +: RB]    = i_ro_status;
  assign rdall[`RAB_IDX_WO*RB +: RB]    = `RAB_RST_VAL;
  assign rdall[`RAB_IDX_W1C*RB +: RB]   = o_w1c;
  assign rdall[`RAB_IDX_STS*RB +: RB]   = sts;
  assign rdall[`RAB_IDX_SW1C*RB +: RB]  = o_sw1c;
  assign rdall[`RAB_IDX_RESERVED_FIELD*RB +: RB]  = `RAB_RST_VAL;
  assign rdall[`RAB_IDX_VRW*RB +: RB]   = o_vrw;
  assign rdall[`RAB_IDX_VLOCK*RB +: RB] = o_vlock;

  // Read selects a register pair; addresses past the bank read as reserved zero
  reg [63:0] next_rdata;
  integer    k;
  always @* begin
    next_rdata = 64'h0000000000000000;
    for (k = 0; k < NR; k = k + 1) begin
      if (qaddr == k[QW-1:0] / 2) begin
        next_rdata[(k%2)*32 +: 32] = rdall[k*RB +: RB];
      end
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata  <= 64'h0000000000000000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req & ~i_write;
      // Capture only on a read so the data holds until the next read
      if (i_req & ~i_write) begin
        o_rdata <= next_rdata;
      end
    end
  end

  // Portal window: a write lands only at the head of an implemented page
  localparam integer NPI = NUM_PORTALS;
  localparam [PW:0]  NP  = NPI[PW:0];
  wire [PW-1:0] page;
  wire          head;
  wire          match;
  assign page  = i_portal_addr[PAW-1:`RAB_PAGE_BITS];
  assign head  = (i_portal_addr[`RAB_PAGE_BITS-1:0] == {`RAB_PAGE_BITS{1'b0}});
  assign match = ({1'b0, page} < NP) && head;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_portal_valid  <= 1'b0;
      o_portal_index  <= {PW{1'b0}};
      o_portal_data   <= {`RAB_PORTAL_BITS{1'b0}};
      o_portal_rdata  <= 64'h0000000000000000;
      o_portal_rvalid <= 1'b0;
    end else begin
      o_portal_valid  <= i_portal_req & i_portal_write & match;
      o_portal_rvalid <= i_portal_req & ~i_portal_write;
      // Portal reads hold no data of their own; every byte reads as fill
      o_portal_rdata  <= {8{`RAB_PORTAL_FILL}};
      if (i_portal_req & i_portal_write & match) begin
        o_portal_index <= page;
        o_portal_data  <= i_portal_wdata;
      end
    end
  end

endmodule

// ==== verif/rab_checker.sv ====
// Port assertions for the register bank
`timescale 1ns/1ps
module rab_checker #(parameter AW = 12) (
  input wire          i_clk,
  input wire          i_resetn,
  input wire          i_req,
  input wire          i_write,
  input wire [AW-1:0] i_addr,
  input wire [31:0]   i_ro_status,
  input wire          i_lock,
  input wire [63:0]   o_rdata,
  input wire          o_rvalid,
  input wire [31:0]   o_lock,
  input wire          o_wo_strobe,
  input wire          i_portal_req,
  input wire [63:0]   o_portal_rdata,
  input wire          o_portal_rvalid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rd;
    i_req && !i_write;
  endsequence
  a_read_answer: assert property (s_rd |=> o_rvalid) else $error("no answer");
  a_no_spurious: assert property (!(i_req && !i_write) |=> !o_rvalid) else $error("stray answer");
  a_lock_hold: assert property (i_lock |=> $stable(o_lock)) else $error("locked change");
  // Odd qwords hold write-only, reserved or unmapped high words
  a_zero_high: assert property (o_rvalid && $past(i_addr[3]) |-> o_rdata[63:32] == 32'h0)
    else $error("high word not zero");
  a_ro_live: assert property (o_rvalid && $past(i_addr[AW-1:3]) == 1 |->
    o_rdata[31:0] == $past(i_ro_status)) else $error("status mismatch");
  a_wo_strobe: assert property (o_wo_strobe |-> $past(i_req && i_write && i_addr[AW-1:3] == 1))
    else $error("stray strobe");
  a_portal_pulse: assert property (o_portal_rvalid |-> $past(i_portal_req)) else $error("stray pulse");
  a_portal_fill: assert property (o_portal_rvalid |-> &o_portal_rdata) else $error("bad fill");
endmodule

// ==== verif/rab_host.sv ====
// Host model issuing window and portal accesses
`timescale 1ns/1ps
module rab_host (
  input  wire         i_clk,
  input  wire [63:0]  i_rdata,
  input  wire         i_rvalid,
  output reg          o_req,
  output reg          o_write,
  output reg  [11:0]  o_addr,
  output reg  [7:0]   o_be,
  output reg  [63:0]  o_wdata,
  output reg          o_preq,
  output reg          o_pwrite,
  output reg  [15:0]  o_paddr,
  output reg  [511:0] o_pdata
);
  reg [63:0] rd;
  reg        tmo;
  initial {o_req, o_write, o_addr, o_be, o_wdata, o_preq, o_pwrite, o_paddr, o_pdata} = 0;
  // Aligned 1, 2, 4 or 8-byte access by lane enables; released lines show inverted data
  task acc(input w, input [11:0] a, input [7:0] b, input [63:0] d);
    begin
      @(negedge i_clk);
      {o_req, o_write, o_addr, o_be, o_wdata} = {1'b1, w, a, b, d};
      @(negedge i_clk);
      {o_req, o_addr, o_wdata} = {1'b0, ~a, ~d};
      tmo = !w && !i_rvalid;
      rd = i_rdata;
    end
  endtask
  task pacc(input w, input [15:0] a, input [511:0] d);
    begin
      @(negedge i_clk);
      {o_preq, o_pwrite, o_paddr, o_pdata} = {1'b1, w, a, d};
      @(negedge i_clk);
      {o_preq, o_pdata} = {1'b0, ~d};
    end
  endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t %h %h", $time, a, b); end end
module testbench;
  reg clk = 0, rstn = 0, srstn = 0, lock = 0, vrw_we = 0, vlk_we = 0;
  reg [31:0] ro_st = 32'hC0FFEE01, sts_st = 32'h5A, w1c_set = 0, sw1c_set = 0, vrw_d = 0, vlk_d = 0;
  wire [63:0] rdata, prdata, wd;
  wire [31:0] rw, lk, wo, w1c, sw1c, vrw, vlk;
  wire [511:0] pdata, pwd;
  wire [15:0] paddr;
  wire [11:0] addr;
  wire [7:0] be;
  wire [3:0] pidx;
  wire rvalid, wstb, pv, prv, req, wr, preq, pwr;
  integer n_errors = 0, compares = 0;
  localparam [511:0] PAT = {16{32'hCAFE0001}};
  always #12.5 clk = ~clk;
  rab_bank uut (.i_clk(clk), .i_resetn(rstn), .i_sticky_resetn(srstn), .i_req(req), .i_write(wr),
    .i_addr(addr), .i_be(be), .i_wdata(wd), .o_rdata(rdata), .o_rvalid(rvalid), .i_lock(lock),
    .i_ro_status(ro_st), .i_sts_status(sts_st), .i_w1c_set(w1c_set), .i_sw1c_set(sw1c_set),
    .i_vrw_we(vrw_we), .i_vrw_data(vrw_d), .i_vlock_we(vlk_we), .i_vlock_data(vlk_d), .o_rw(rw),
    .o_lock(lk), .o_wo(wo), .o_wo_strobe(wstb), .o_w1c(w1c), .o_sw1c(sw1c), .o_vrw(vrw), .o_vlock(vlk),
    .i_portal_req(preq), .i_portal_write(pwr), .i_portal_addr(paddr), .i_portal_wdata(pwd),
    .o_portal_valid(pv), .o_portal_index(pidx), .o_portal_data(pdata), .o_portal_rdata(prdata),
    .o_portal_rvalid(prv));
  rab_host h (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req), .o_write(wr), .o_addr(addr),
    .o_be(be), .o_wdata(wd), .o_preq(preq), .o_pwrite(pwr), .o_paddr(paddr), .o_pdata(pwd));
  task final_report;
    begin
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task rd(input [11:0] a);
    begin
      h.acc(0, a, 8'h00, 64'h0);
      if (h.tmo) begin
        n_errors++;
        final_report;
      end
    end
  endtask
  task t_rw_lock;
    begin
      h.acc(1, 12'h000, 8'hFF, 64'h123456789ABCDEF0);
      h.acc(1, 12'h000, 8'h01, 64'hFFFFFFFFFFFFFF55);
      rd(12'h000);
      `CHK(h.rd, 64'h123456789ABCDE55)
      lock = 1;
      h.acc(1, 12'h000, 8'hF0, 64'hAAAAAAAA00000000);
      `CHK(lk, 32'h12345678)
      lock = 0;
      h.acc(1, 12'h008, 8'hFF, 64'hFFFFFFFFFFFFFFFF);
      `CHK(wstb, 1'b1)
      rd(12'h008);
      `CHK(wstb, 1'b0)
      `CHK(h.rd, 64'h00000000C0FFEE01)
      `CHK(wo, 32'hFFFFFFFF)
    end
  endtask
  task t_clear_sticky;
    begin
      {w1c_set, sw1c_set} = {32'hF, 32'hF};
      @(negedge clk);
      {w1c_set, sw1c_set} = 0;
      h.acc(1, 12'h010, 8'hFF, 64'hFFFFFFFF00000005);
      h.acc(1, 12'h018, 8'hFF, 64'h0000000000000003);
      rd(12'h010);
      `CHK(h.rd, 64'h0000005A0000000A)
      rd(12'h018);
      `CHK(h.rd, 64'h000000000000000C)
      // Read taken at the first edge after release; sts keeps loading the status all through the device reset
      rstn = 0;
      fork
        begin
          @(negedge clk);
          rstn = 1;
        end
        rd(12'h010);
      join
      `CHK(sw1c, 32'hC)
      `CHK(w1c, 32'h0)
      `CHK(h.rd[31:0], 32'h0)
      `CHK(h.rd[63:32], 32'h5A)
    end
  endtask
  task t_volatile;
    begin
      {vrw_d, vrw_we, vlk_d, vlk_we} = {32'h11, 1'b1, 32'h44, 1'b0};
      @(negedge clk);
      vrw_we = 0;
      `CHK(vrw, 32'h11)
      lock = 1;
      h.acc(1, 12'h020, 8'hFF, 64'h0000003300000022);
      `CHK(vrw, 32'h22)
      `CHK(vlk, 32'h0)
      vlk_we = 1;
      @(negedge clk);
      vlk_we = 0;
      lock = 0;
      `CHK(vlk, 32'h44)
    end
  endtask
  task t_portal;
    begin
      h.pacc(1, 16'h3000, PAT);
      `CHK(pv, 1'b1)
      `CHK(pidx, 4'h3)
      h.pacc(1, 16'h3040, ~PAT);
      `CHK(pv, 1'b0)
      `CHK(pdata, PAT)
      h.pacc(0, 16'h5000, 512'h0);
      `CHK(prdata, 64'hFFFFFFFFFFFFFFFF)
      `CHK(prv, 1'b1)
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    {rstn, srstn} = 2'b11;
    t_rw_lock;
    t_clear_sticky;
    t_volatile;
    t_portal;
    final_report;
  end
endmodule
bind rab_bank rab_checker #(.AW(AW)) chk (.i_clk, .i_resetn, .i_req, .i_write, .i_addr, .i_ro_status,
  .i_lock, .o_rdata, .o_rvalid, .o_lock, .o_wo_strobe, .i_portal_req, .o_portal_rdata, .o_portal_rvalid);
